//--- bench/itc_control_word_properties.sv
/* Checker for the interval timer command decode ports.
   Assumes one clock domain and binding onto itc_control_word. */
`timescale 1ns/1ps
module itc_control_word_checker
    import itc_pkg::*;
(
    input wire logic                         sys_clk,
    input wire logic                         rst,
    input wire itc_io_req_t                  io_req,
    input wire logic [7:0]                   io_rdata,
    input wire logic                         io_rack,
    input wire logic [ITC_NUM_CNT-1:0]       ce_out,
    input wire itc_cfg_t [ITC_NUM_CNT-1:0]   cnt_cfg,
    input wire logic [ITC_NUM_CNT-1:0]       cnt_cfg_wr,
    input wire itc_load_t [ITC_NUM_CNT-1:0]  cnt_load,
    input wire logic [ITC_NUM_CNT-1:0]       cnt_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Control port write, and the subset that programs a counter
    sequence s_ctl;
        io_req.wr && io_req.addr == ITC_PORT_CTRL;
    endsequence
    sequence s_prog;
        s_ctl ##0 io_req.wdata[7:6] != ITC_SEL_READBACK && io_req.wdata[5:4] != ITC_RW_LATCH;
    endsequence
    property p_rack; io_req.rd |=> io_rack; endproperty
    a_rack: assert property (p_rack) else $error("read not answered");
    property p_no_rack; !io_req.rd |=> !io_rack; endproperty
    a_no_rack: assert property (p_no_rack) else $error("stray read answer");
    property p_ctl_rd; io_req.rd && io_req.addr == ITC_PORT_CTRL |=> io_rdata == ITC_RDATA_IDLE;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control port read not idle");
    property p_cfg_wr; s_prog |-> cnt_cfg_wr[io_req.wdata[7:6]]; endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("wrong counter selected");
    property p_cfg;
        s_prog |=> cnt_cfg[$past(io_req.wdata[7:6])].rw == $past(io_req.wdata[5:4])
            && cnt_cfg[$past(io_req.wdata[7:6])].mode[1:0] == $past(io_req.wdata[2:1])
            && cnt_cfg[$past(io_req.wdata[7:6])].bcd == $past(io_req.wdata[0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("setting not stored");
    property p_no_cfg;
        s_ctl ##0 (io_req.wdata[7:6] == ITC_SEL_READBACK || io_req.wdata[5:4] == ITC_RW_LATCH)
            |-> cnt_cfg_wr == '0;
    endproperty
    a_no_cfg: assert property (p_no_cfg) else $error("command reprogrammed");
    property p_out_gate; (cnt_out & ~ce_out) == '0; endproperty
    a_out_gate: assert property (p_out_gate) else $error("output high without source");
    property p_mode_fold;
        !((cnt_cfg[0].mode[2] && cnt_cfg[0].mode[1]) || (cnt_cfg[1].mode[2] && cnt_cfg[1].mode[1])
            || (cnt_cfg[2].mode[2] && cnt_cfg[2].mode[1]));
    endproperty
    a_mode_fold: assert property (p_mode_fold) else $error("mode top bit not folded");
    property p_out_rst; $fell(rst) |-> cnt_out == '0; endproperty
    a_out_rst: assert property (p_out_rst) else $error("output high after reset");
    property p_load0; cnt_load[0].load |-> $past(io_req.wr) && $past(io_req.addr) == ITC_PORT_CNT0;
    endproperty
    a_load0: assert property (p_load0) else $error("load without data write");
endmodule // itc_control_word_checker

bind itc_control_word itc_control_word_checker u_chk (.sys_clk, .rst, .io_req, .io_rdata,
    .io_rack, .ce_out, .cnt_cfg, .cnt_cfg_wr, .cnt_load, .cnt_out);

//--- bench/itc_control_word_tb.sv
/* Self-checking bench for the interval timer command decode.
   Assumes the bench plays host and counting elements; inputs move at falling edges. */
`timescale 1ns/1ps
module itc_control_word_tb
    import itc_pkg::*;
;
    logic                          sys_clk, rst, io_rack;
    itc_io_req_t                   io_req;
    logic [7:0]                    io_rdata;
    logic [ITC_NUM_CNT-1:0][15:0]  ce_count;
    logic [ITC_NUM_CNT-1:0]        ce_out, ce_null, cnt_cfg_wr, cnt_out;
    itc_cfg_t [ITC_NUM_CNT-1:0]    cnt_cfg;
    itc_load_t [ITC_NUM_CNT-1:0]   cnt_load;
    int                            mismatches, checked;

    itc_control_word u_dut (.sys_clk, .rst, .io_req, .io_rdata, .io_rack, .ce_count,
        .ce_out, .ce_null, .cnt_cfg, .cnt_cfg_wr, .cnt_load, .cnt_out);

    // Compare helpers, one per result width
    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // One I/O cycle; idle gap after it avoids double drive at one edge
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        io_req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(negedge sys_clk);
        io_req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cyc(1'b0, 1'b1, a, 8'h00);
        chk_b({7'h00, io_rack}, 8'h01);
        chk_b(io_rdata, exp);
    endtask

    task automatic t_reset;
        ce_out = 3'h7;
        #1 chk_b({5'h00, cnt_out}, 8'h00);
        rd(ITC_PORT_CTRL, ITC_RDATA_IDLE);
        rd(8'h44, ITC_RDATA_IDLE);
    endtask
    task automatic t_prog0;
        wr(ITC_PORT_CTRL, 8'h34);
        chk_b({2'h0, cnt_cfg[0]}, 8'h34);
        wr(ITC_PORT_CNT0, 8'hCD);
        wr(ITC_PORT_CNT0, 8'hAB);
        chk_w(cnt_load[0], 17'h1ABCD);
        chk_b({5'h00, cnt_out}, 8'h01);
    endtask
    // Second latch must not refresh the held count
    task automatic t_latch;
        ce_count[0] = 16'h1234;
        wr(ITC_PORT_CTRL, 8'h00);
        ce_count[0] = 16'h5678;
        wr(ITC_PORT_CTRL, 8'h0F);
        chk_b({2'h0, cnt_cfg[0]}, 8'h34);
        rd(ITC_PORT_CNT0, 8'h34);
        wr(ITC_PORT_CTRL, 8'h7B);
        rd(ITC_PORT_CNT0, 8'h12);
        rd(ITC_PORT_CNT0, 8'h78);
    endtask
    task automatic t_rdbk;
        chk_b({2'h0, cnt_cfg[1]}, 8'h3B);
        ce_null = 3'h4;
        ce_count[1] = 16'h9A87;
        ce_count[0] = 16'h1111;
        wr(ITC_PORT_CTRL, 8'hC4);
        ce_count[1] = 16'h0000;
        ce_count[0] = 16'h2222;
        rd(8'h41, 8'hBB);
        rd(ITC_PORT_CNT0, 8'h22);
        rd(8'h41, 8'h87);
        rd(8'h41, 8'h9A);
        rd(8'h41, 8'h00);
    endtask
    // Upper mode bit dropped for x10; status only, count suppressed
    task automatic t_mode2;
        ce_out = 3'h3;
        wr(ITC_PORT_CTRL, 8'h9C);
        chk_b({2'h0, cnt_cfg[2]}, 8'h14);
        wr(8'h42, 8'h5A);
        chk_w(cnt_load[2], 17'h1005A);
        ce_count[2] = 16'h4321;
        wr(ITC_PORT_CTRL, 8'hE9);
        rd(8'h42, 8'h5C);
        rd(8'h42, 8'h21);
    endtask
    // All three counters snapped at once, read back interleaved
    task automatic t_multi;
        wr(ITC_PORT_CTRL, 8'h7B);
        ce_count = {16'hC2C1, 16'hB2B1, 16'hA2A1};
        wr(ITC_PORT_CTRL, 8'hDE);
        ce_count = '0;
        rd(8'h42, 8'hC1);
        rd(ITC_PORT_CNT0, 8'hA1);
        rd(8'h41, 8'hB1);
        rd(ITC_PORT_CNT0, 8'hA2);
        rd(8'h41, 8'hB2);
    endtask
    // Mid-run reset drops programming; data writes then ignored
    task automatic t_rerst;
        ce_out = 3'h7;
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk_b({5'h00, cnt_out}, 8'h00);
        wr(ITC_PORT_CNT0, 8'h55);
        chk_w(cnt_load[0], 17'h00000);
    endtask

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Watchdog far beyond the 78 cycles used
    initial begin
        #50000;
        mismatches++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        io_req = '0;
        ce_count = '0;
        ce_out = '0;
        ce_null = '0;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_prog0();
        t_latch();
        t_rdbk();
        t_mode2();
        t_multi();
        t_rerst();
        wrap_up();
    end
endmodule // itc_control_word_tb

//--- hdl/itc_control_word.sv
/*
 * Command decode and access-port sequencing for a three-channel interval timer.
 * Assumes the counting elements sit outside and report live count, output level
 * and null-count; host I/O strobes are one-cycle pulses synchronous to sys_clk.
 */
// Contract
// - After reset every counter output is low; settings all zero until programmed.
// - Bits 7:6 pick counter 0, 1, 2, or 11 for read-back.
// - Bits 5:4: 00 latch, 01 low byte, 10 high byte, 11 low then high.
// - Counts load and read through ports 40h-42h in the programmed byte format.
// - Bits 3:1 select mode; top bit ignored for x10 and x11.
// - Bit 0 selects binary or four-digit BCD countdown.
// - Read-back snapshots all selected counters at once; others untouched.
// - Read-back bits 3,2,1 select counters 2,1,0; bit 0 reserved.
// - Read-back bit5 zero snapshots count, bit4 zero snapshots status.
// - Snapshots hold until read; further latches ignored meanwhile.
// - With both snapshots: status first, then held count, then live count.
// - Latch command (rw 00, not read-back) snapshots that counter's count.
// - Byte sequencing is independent per counter.
// - A second latch before the held count is read is ignored.
// - Status: bit7 output, bit6 null count, bits5:0 programmed setting.
`timescale 1ns/1ps

module itc_control_word
    import itc_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire itc_io_req_t               io_req,
    output logic        [7:0]              io_rdata,
    output logic                           io_rack,
    input  wire logic   [ITC_NUM_CNT-1:0][15:0] ce_count,
    input  wire logic   [ITC_NUM_CNT-1:0]  ce_out,
    input  wire logic   [ITC_NUM_CNT-1:0]  ce_null,
    output itc_cfg_t    [ITC_NUM_CNT-1:0]  cnt_cfg,
    output logic        [ITC_NUM_CNT-1:0]  cnt_cfg_wr,
    output itc_load_t   [ITC_NUM_CNT-1:0]  cnt_load,
    output logic        [ITC_NUM_CNT-1:0]  cnt_out
);

    // Control word decode, shared by all channels
    // Writes to 43h only act here; the port itself never answers with data
    logic       ctrl_wr;
    logic [1:0] cw_sel;
    logic [1:0] cw_rw;
    logic       rb_cmd;
    assign ctrl_wr = io_req.wr && (io_req.addr == ITC_PORT_CTRL);
    assign cw_sel  = io_req.wdata[ITC_SEL_HI:ITC_SEL_LO];
    assign cw_rw   = io_req.wdata[ITC_RW_HI:ITC_RW_LO];
    assign rb_cmd  = ctrl_wr && (cw_sel == ITC_SEL_READBACK);

    // Per-channel read byte and hit, merged into one registered answer
    logic [ITC_NUM_CNT-1:0][7:0] rd_byte;
    logic [ITC_NUM_CNT-1:0]      rd_hit;

    // One slice per counter; each keeps its own snapshots and byte pointers,
    // so traffic to another counter never disturbs a half-read count
    genvar i;
    generate
        for (i = 0; i < ITC_NUM_CNT; i++) begin : g_cnt
            // Slice state and decode
            logic        programmed;
            itc_cfg_t    cfg;
            logic        cnt_held;
            logic [15:0] cnt_snap;
            logic        st_held;
            logic [7:0]  st_snap;
            logic        rd_msb;
            logic        wr_msb;
            logic [7:0]  wr_lsb;
            logic        port_wr;
            logic        port_rd;
            logic        sel_me;
            logic        cfg_cmd;
            logic        latch_cmd;
            logic        rb_me;
            logic        take_cnt;
            logic        take_st;
            logic [7:0]  status_now;
            logic [15:0] cnt_src;
            logic        hi_byte;

            // Data port and control word hits for this slice
            assign port_wr   = io_req.wr && (io_req.addr == ITC_PORT_CNT0 + 8'(i));
            assign port_rd   = io_req.rd && (io_req.addr == ITC_PORT_CNT0 + 8'(i));
            assign sel_me    = ctrl_wr && (cw_sel == 2'(i));
            assign cfg_cmd   = sel_me && (cw_rw != ITC_RW_LATCH);
            assign latch_cmd = sel_me && (cw_rw == ITC_RW_LATCH);
            assign rb_me     = rb_cmd && io_req.wdata[ITC_RB_SEL0 + i];
            // Held values win over new requests until they are read out;
            // reserved low bits of latch and read-back words are never looked at
            assign take_cnt  = !cnt_held && (latch_cmd ||
                               (rb_me && !io_req.wdata[ITC_RB_NOCNT]));
            assign take_st   = !st_held && rb_me && !io_req.wdata[ITC_RB_NOSTAT];
            assign status_now = {cnt_out[i], ce_null[i], cfg};

            // Programmed settings; reserved bits of latch and read-back never land here
            // Limitation: until then the element sees an all-zero setting
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    programmed <= 1'b0;
                    cfg        <= ITC_CFG_RESET;
                end else if (cfg_cmd) begin
                    programmed <= 1'b1;
                    cfg.rw     <= cw_rw;
                    cfg.mode   <= io_req.wdata[ITC_MODE_HI:ITC_MODE_LO];
                    cfg.bcd    <= io_req.wdata[ITC_BCD_BIT];
                end
            end

            // Mode top bit dropped for x10/x11 so the element sees one code each
            always_comb begin
                cnt_cfg[i] = cfg;
                if (cfg.mode[1]) begin
                    cnt_cfg[i].mode = {1'b0, cfg.mode[1:0]};
                end
            end
            // Config strobe is the raw decode, one cycle, for the element to reload
            assign cnt_cfg_wr[i] = cfg_cmd;
            // Output forced low until programmed, whatever the element reports
            assign cnt_out[i]    = programmed && ce_out[i];

            // Count snapshot; a read in the snapshot cycle does not release it,
            // so the host may see one stale byte but never loses the new hold
            always_ff @(posedge sys_clk) begin
                if (rst || cfg_cmd) begin
                    cnt_held <= 1'b0;
                    cnt_snap <= 16'h0000;
                end else if (take_cnt) begin
                    cnt_held <= 1'b1;
                    cnt_snap <= ce_count[i];
                end else if (port_rd && !st_held && cnt_held &&
                             (cfg.rw != ITC_RW_LSB_MSB || rd_msb)) begin
                    cnt_held <= 1'b0;
                end
            end

            // Status snapshot, always read before the count
            // A pending status byte blocks release of the count behind it
            always_ff @(posedge sys_clk) begin
                if (rst || cfg_cmd) begin
                    st_held <= 1'b0;
                    st_snap <= 8'h00;
                end else if (take_st) begin
                    st_held <= 1'b1;
                    st_snap <= status_now;
                end else if (port_rd) begin
                    st_held <= 1'b0;
                end
            end

            // Per-channel read byte pointer; status reads do not move it
            // Live reads move it too, so two-byte counts should be read in pairs
            always_ff @(posedge sys_clk) begin
                if (rst || cfg_cmd) begin
                    rd_msb <= 1'b0;
                end else if (port_rd && !st_held && cfg.rw == ITC_RW_LSB_MSB) begin
                    rd_msb <= !rd_msb;
                end
            end

            // Write pointer; a two-byte load goes out only after the high byte
            // Low byte parked here so the element never sees a half-written count
            always_ff @(posedge sys_clk) begin
                if (rst || cfg_cmd) begin
                    wr_msb      <= 1'b0;
                    wr_lsb      <= 8'h00;
                    cnt_load[i] <= '0;
                end else begin
                    cnt_load[i].load <= 1'b0;
                    if (port_wr) begin
                        case (cfg.rw)
                            ITC_RW_LSB: begin
                                cnt_load[i] <= {1'b1, 8'h00, io_req.wdata};
                            end
                            ITC_RW_MSB: begin
                                cnt_load[i] <= {1'b1, io_req.wdata, 8'h00};
                            end
                            ITC_RW_LSB_MSB: begin
                                wr_msb <= !wr_msb;
                                if (wr_msb) begin
                                    cnt_load[i] <= {1'b1, io_req.wdata, wr_lsb};
                                end else begin
                                    wr_lsb <= io_req.wdata;
                                end
                            end
                            default: begin
                                wr_msb <= wr_msb;            // Unprogrammed: ignored
                            end
                        endcase
                    end
                end
            end

            // Byte presented on a read: status, then held count, then live count
            // Trade-off: combinational select here, one register stage at the merge
            assign cnt_src = cnt_held ? cnt_snap : ce_count[i];
            assign hi_byte = (cfg.rw == ITC_RW_MSB) ||
                             (cfg.rw == ITC_RW_LSB_MSB && rd_msb);
            assign rd_byte[i] = st_held ? st_snap :
                                (hi_byte ? cnt_src[15:8] : cnt_src[7:0]);
            assign rd_hit[i]  = port_rd;
        end
    endgenerate

    // Registered read answer; the control port is write-only and reads as idle
    // Every read strobe is answered, unmapped ports included, so the host never stalls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_rdata <= ITC_RDATA_IDLE;
            io_rack  <= 1'b0;
        end else begin
            io_rack  <= io_req.rd;
            io_rdata <= ITC_RDATA_IDLE;
            for (int k = 0; k < ITC_NUM_CNT; k++) begin
                if (rd_hit[k]) begin
                    io_rdata <= rd_byte[k];
                end
            end
        end
    end

endmodule // itc_control_word

//--- hdl/itc_pkg.sv
/*
 * Shared constants and types for the interval timer command decode.
 * Assumes an 8-bit I/O port space and three external counting elements.
 */
package itc_pkg;

    // Port map
    localparam logic [7:0] ITC_PORT_CNT0    = 8'h40;
    localparam logic [7:0] ITC_PORT_CTRL    = 8'h43;
    localparam int         ITC_NUM_CNT      = 3;

    // Control word fields
    localparam int         ITC_SEL_HI       = 7;
    localparam int         ITC_SEL_LO       = 6;
    localparam int         ITC_RW_HI        = 5;
    localparam int         ITC_RW_LO        = 4;
    localparam int         ITC_MODE_HI      = 3;
    localparam int         ITC_MODE_LO      = 1;
    localparam int         ITC_BCD_BIT      = 0;
    localparam int         ITC_RB_NOCNT     = 5;
    localparam int         ITC_RB_NOSTAT    = 4;
    localparam int         ITC_RB_SEL0      = 1;

    // Encodings
    localparam logic [1:0] ITC_SEL_READBACK = 2'h3;
    localparam logic [1:0] ITC_RW_LATCH     = 2'h0;
    localparam logic [1:0] ITC_RW_LSB       = 2'h1;
    localparam logic [1:0] ITC_RW_MSB       = 2'h2;
    localparam logic [1:0] ITC_RW_LSB_MSB   = 2'h3;

    // Values after reset and for unmapped reads
    localparam logic [7:0] ITC_RDATA_IDLE   = 8'h00;
    localparam logic [5:0] ITC_CFG_RESET    = 6'h00;

    // Per-counter programmed setting
    typedef struct packed {
        logic [1:0] rw;
        logic [2:0] mode;
        logic       bcd;
    } itc_cfg_t;

    // One host I/O cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } itc_io_req_t;

    // Count handed to a counting element
    typedef struct packed {
        logic        load;
        logic [15:0] value;
    } itc_load_t;

endpackage
